// ---- hw/carrier_sincos.sv ----
`timescale 1ns/10ps
// parabolic sine approximation; cheaper than a table, purity limited to roughly -30 dBc
module carrier_sincos (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // phase in
  input wire logic [15:0] phase,
  input wire logic force_zero,
  // quadrature terms
  output logic signed [upc_pkg::TRIG_W-1:0] sin_term,
  output logic signed [upc_pkg::TRIG_W-1:0] cos_term
);
  import upc_pkg::*;

  function automatic logic signed [TRIG_W-1:0] parab(input logic [15:0] p);
    logic [15:0] u;
    logic [31:0] prod;
    logic [31:0] mag;
    u = {1'b0, p[14:0]};
    prod = 32'(u) * 32'(16'h8000 - u);
    mag = prod >> 10;
    if (mag > 32'h0003FFFF) mag = 32'h0003FFFF;
    return p[15] ? -$signed(mag[TRIG_W-1:0]) : $signed(mag[TRIG_W-1:0]);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      sin_term <= '0;
      cos_term <= COS_ONE;
    end else if (force_zero) begin
      sin_term <= '0; // R11
      cos_term <= COS_ONE; // R11
    end else begin
      sin_term <= parab(phase);
      cos_term <= parab(phase + 16'h4000);
    end
  end
endmodule

// ---- hw/upc_pkg.sv ----
package upc_pkg;
  // bus geometry: register index = byte address / 4
  localparam int ADDR_W = 9;
  localparam int REG_W = 16;
  localparam logic [6:0] IDX_PHASE_OFS = 7'h07;
  localparam logic [6:0] IDX_FREQ_HI = 7'h08;
  localparam logic [6:0] IDX_FREQ_LO = 7'h09;
  localparam logic [6:0] IDX_MAIN_CTRL = 7'h0C;
  localparam logic [6:0] IDX_FIR_CTRL = 7'h0D;
  localparam logic [6:0] IDX_DEV_CTRL = 7'h78;
  localparam logic [6:0] IDX_ROUTE = 7'h79;
  localparam logic [6:0] IDX_STATUS = 7'h7A;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions
  localparam int MAIN_CPLX_BIT = 7;
  localparam int FIR_HB_EN_BIT = 9;
  localparam int DEV_X2_BIT = 10;
  localparam int DEV_MODE_LSB = 8;
  localparam int DEV_STRB_EN_BIT = 5;
  localparam int DEV_CASC_EN_BIT = 3;
  localparam int DEV_DELAY_LSB = 1;
  localparam int ROUTE_LSB = 0;
  localparam int CPLX_KIND_LSB = 4;

  // datapath widths
  localparam int SAMPLE_W = 20;
  localparam int MIX_W = 21;
  localparam int TRIG_W = 19;
  localparam int PHASE_W = 32;
  localparam int TRIG_SHIFT = 18;
  localparam logic signed [TRIG_W-1:0] COS_ONE = 19'sh3FFFF;

  // halfband weights, unity gain per phase is 256
  localparam int HB_C0 = 3;
  localparam int HB_C2 = -25;
  localparam int HB_C4 = 150;
  localparam int HB_SHIFT = 8;
  localparam logic signed [47:0] HB_ROUND = 48'sh000000000080;

  typedef enum logic [1:0] {MODE_CASCADE, MODE_REAL, MODE_IMAG, MODE_MUXED} out_mode_e;

  function automatic logic signed [SAMPLE_W-1:0] sat20(input logic signed [47:0] v);
    if (v > 48'sh00000007FFFF) return 20'sh7FFFF;
    if (v < -48'sh00000007FFFF) return -20'sh7FFFF;
    return v[SAMPLE_W-1:0];
  endfunction

  function automatic logic signed [MIX_W-1:0] sat21(input logic signed [47:0] v);
    if (v > 48'sh0000000FFFFF) return 21'shFFFFF;
    if (v < -48'sh0000000FFFFF) return -21'shFFFFF;
    return v[MIX_W-1:0];
  endfunction
endpackage

// ---- hw/upconverter_channel_back_end.sv ----
`timescale 1ns/10ps
// Overview of operation
// R1: halfband stage bypassed after reset; fir control bit 9 enables it.
// R2: while bypassed, data entering the halfband delay line is forced to zero.
// R3: halfband interpolates by two with taps 3,0,-25,0,150,256,150,0,-25,0,3.
// R4: halfband result rounded to 20 bits and clamped on saturation.
// R5: interpolator delivers one I and Q sample per clock from fine phase.
// R6: carrier oscillator uses 32-bit two's complement increment.
// R7: frequency word written as upper half at 0x8, lower half at 0x9.
// R8: positive frequency rotates counterclockwise, negative clockwise.
// R9: phase offset loads upper accumulator half and clears the lower half.
// R10: accumulator feedback can be preset so channels start in step.
// R11: zero frequency gives sine 0 and cosine 1, mixer passes I and Q.
// R12: real = I*cos - Q*sin, imag = Q*cos + I*sin, 21-bit results.
// R13: routing chosen by mode bits 9:8 at 0x78 and complex bit 7 at 0xc.
// R14: only cascade mode takes cascade buses as inputs; sums drive output buses.
// R15: cascade delay bits 2:1 at 0x78 delay the local sum.
// R16: cascade enable bit 3 clear substitutes zero for cascade input data.
// R17: local plus cascade sum saturates instead of wrapping.
// R18: mode 01 carries real parts of summers 1-4, mode 10 imaginary parts.
// R19: mode 11 alternates real then imaginary, strobes real, decimates by two.
// R20: real sample strobe driven only when bit 5 at 0x78 enables it.
// R21: 2x select with mode 01 gives real while clock high, imaginary low.
// R22: complex bit with mode 01 selects complex output arrangements 1, 2, 3.
// R23: accumulator adds increment each clock modulo 2^32, top bits feed sin/cos.
module upconverter_channel_back_end #(
  parameter int FINE_W = 8,
  parameter int CASC_DEPTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite register slave
  input wire logic [upc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [upc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // shaped samples and sample-rate phase
  input wire logic signed [upc_pkg::SAMPLE_W-1:0] shaped_i,
  input wire logic signed [upc_pkg::SAMPLE_W-1:0] shaped_q,
  input wire logic shaped_valid,
  input wire logic [FINE_W-1:0] fine_phase,
  // other channels' mixer results per summer
  input wire logic signed [3:0][upc_pkg::MIX_W-1:0] peer_re,
  input wire logic signed [3:0][upc_pkg::MIX_W-1:0] peer_im,
  // cascade buses, two-way
  input wire logic signed [upc_pkg::SAMPLE_W-1:0] cascade_real_bus_in,
  output logic signed [upc_pkg::SAMPLE_W-1:0] cascade_real_bus_out,
  output logic cascade_real_bus_oe,
  input wire logic signed [upc_pkg::SAMPLE_W-1:0] cascade_imag_bus_in,
  output logic signed [upc_pkg::SAMPLE_W-1:0] cascade_imag_bus_out,
  output logic cascade_imag_bus_oe,
  // output buses
  output logic signed [upc_pkg::SAMPLE_W-1:0] first_output_bus,
  output logic signed [upc_pkg::SAMPLE_W-1:0] second_output_bus,
  output logic real_sample_strobe
);
  import upc_pkg::*;

  if (FINE_W < 1 || FINE_W > 16) begin : g_fine_chk
    $error("FINE_W must be 1 to 16");
  end
  if (CASC_DEPTH != 3) begin : g_casc_chk
    $error("CASC_DEPTH must be 3, the delay field is two bits");
  end

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------- register file ----------------
  logic [REG_W-1:0] carrier_phase_offset_word;
  logic [REG_W-1:0] carrier_frequency_high;
  logic [REG_W-1:0] carrier_frequency_low;
  logic [REG_W-1:0] main_ctrl;
  logic [REG_W-1:0] fir_ctrl;
  logic [REG_W-1:0] dev_ctrl;
  logic [REG_W-1:0] route_ctrl;
  logic [PHASE_W-1:0] carrier_freq_word;
  logic aw_hold;
  logic w_hold;
  logic [6:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_mapped;
  logic ofs_load;
  logic [PHASE_W-1:0] phase_acc;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_mapped = aw_idx inside {IDX_PHASE_OFS, IDX_FREQ_HI, IDX_FREQ_LO, IDX_MAIN_CTRL,
                                    IDX_FIR_CTRL, IDX_DEV_CTRL, IDX_ROUTE, IDX_STATUS};

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_idx <= s_axi_awaddr[8:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // frequency takes effect as a whole word on the low-half write, so no torn word is used
  always_ff @(posedge clk) begin
    if (rst) begin
      carrier_phase_offset_word <= REG_RESET;
      carrier_frequency_high <= REG_RESET;
      carrier_frequency_low <= REG_RESET;
      main_ctrl <= REG_RESET;
      fir_ctrl <= REG_RESET; // R1
      dev_ctrl <= REG_RESET;
      route_ctrl <= REG_RESET;
      carrier_freq_word <= '0;
      ofs_load <= 1'b0;
    end else begin
      ofs_load <= wr_fire && aw_idx == IDX_PHASE_OFS; // R10
      if (wr_fire) begin
        case (aw_idx)
          IDX_PHASE_OFS: carrier_phase_offset_word <= merge(carrier_phase_offset_word, w_data, w_strb);
          IDX_FREQ_HI: carrier_frequency_high <= merge(carrier_frequency_high, w_data, w_strb); // R7
          IDX_FREQ_LO: begin
            carrier_frequency_low <= merge(carrier_frequency_low, w_data, w_strb); // R7
            carrier_freq_word <= {carrier_frequency_high,
                                  merge(carrier_frequency_low, w_data, w_strb)}; // R7
          end
          IDX_MAIN_CTRL: main_ctrl <= merge(main_ctrl, w_data, w_strb);
          IDX_FIR_CTRL: fir_ctrl <= merge(fir_ctrl, w_data, w_strb);
          IDX_DEV_CTRL: dev_ctrl <= merge(dev_ctrl, w_data, w_strb);
          IDX_ROUTE: route_ctrl <= merge(route_ctrl, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr[8:2])
        IDX_PHASE_OFS: s_axi_rdata <= {16'h0000, carrier_phase_offset_word};
        IDX_FREQ_HI: s_axi_rdata <= {16'h0000, carrier_frequency_high};
        IDX_FREQ_LO: s_axi_rdata <= {16'h0000, carrier_frequency_low};
        IDX_MAIN_CTRL: s_axi_rdata <= {16'h0000, main_ctrl};
        IDX_FIR_CTRL: s_axi_rdata <= {16'h0000, fir_ctrl};
        IDX_DEV_CTRL: s_axi_rdata <= {16'h0000, dev_ctrl};
        IDX_ROUTE: s_axi_rdata <= {16'h0000, route_ctrl};
        IDX_STATUS: s_axi_rdata <= {16'h0000, phase_acc[31:16]};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- halfband, both lanes ----------------
  logic hb_en;
  logic signed [SAMPLE_W-1:0] dl [2][6];
  logic signed [SAMPLE_W-1:0] byp [2];
  logic signed [SAMPLE_W-1:0] hb_y [2];
  logic signed [47:0] phase_a [2];
  logic in_q;
  logic hb_pend;
  logic hb_valid;

  assign hb_en = fir_ctrl[FIR_HB_EN_BIT]; // R1

  always_comb begin
    for (int l = 0; l < 2; l++) begin
      phase_a[l] = HB_C0 * (48'(dl[l][0]) + 48'(dl[l][5])) +
                   HB_C2 * (48'(dl[l][1]) + 48'(dl[l][4])) +
                   HB_C4 * (48'(dl[l][2]) + 48'(dl[l][3])); // R3
    end
  end

  // input samples must be two or more clocks apart while the halfband runs
  always_ff @(posedge clk) begin
    if (rst) begin
      in_q <= 1'b0;
      hb_pend <= 1'b0;
      hb_valid <= 1'b0;
      for (int l = 0; l < 2; l++) begin
        byp[l] <= '0;
        hb_y[l] <= '0;
        for (int k = 0; k < 6; k++) dl[l][k] <= '0;
      end
    end else begin
      in_q <= shaped_valid;
      hb_valid <= 1'b0;
      if (shaped_valid) begin
        byp[0] <= shaped_i;
        byp[1] <= shaped_q;
        dl[0][0] <= hb_en ? shaped_i : '0; // R2
        dl[1][0] <= hb_en ? shaped_q : '0; // R2
        for (int l = 0; l < 2; l++) begin
          for (int k = 1; k < 6; k++) dl[l][k] <= dl[l][k-1];
        end
      end
      if (in_q) begin
        hb_valid <= 1'b1;
        hb_pend <= hb_en;
        for (int l = 0; l < 2; l++) begin
          hb_y[l] <= hb_en ? sat20((phase_a[l] + HB_ROUND) >>> HB_SHIFT) : byp[l]; // R4
        end
      end else if (hb_pend) begin
        hb_valid <= 1'b1;
        hb_pend <= 1'b0;
        for (int l = 0; l < 2; l++) hb_y[l] <= dl[l][2]; // R3
      end
    end
  end

  // ---------------- resampling interpolator ----------------
  logic signed [SAMPLE_W-1:0] ip_prev [2];
  logic signed [SAMPLE_W-1:0] ip_cur [2];
  logic signed [MIX_W-1:0] ip_y [2];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int l = 0; l < 2; l++) begin
        ip_prev[l] <= '0;
        ip_cur[l] <= '0;
        ip_y[l] <= '0;
      end
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (hb_valid) begin
          ip_prev[l] <= ip_cur[l];
          ip_cur[l] <= hb_y[l];
        end
        ip_y[l] <= sat21(48'(ip_prev[l]) + ((48'(ip_cur[l]) - 48'(ip_prev[l])) *
                   $signed({1'b0, 32'(fine_phase)}) >>> FINE_W)); // R5
      end
    end
  end

  // ---------------- carrier oscillator and mixer ----------------
  logic freq_zero;
  logic signed [TRIG_W-1:0] sin_term;
  logic signed [TRIG_W-1:0] cos_term;
  logic signed [MIX_W-1:0] mix_re;
  logic signed [MIX_W-1:0] mix_im;
  logic signed [47:0] re_full;
  logic signed [47:0] im_full;

  assign freq_zero = carrier_freq_word == '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_acc <= '0;
    end else if (ofs_load) begin
      phase_acc <= {carrier_phase_offset_word, 16'h0000}; // R9
    end else begin
      phase_acc <= phase_acc + carrier_freq_word; // R6 R23
    end
  end

  carrier_sincos u_sincos (
    .clk(clk),
    .rst(rst),
    .phase(phase_acc[31:16]), // R23
    .force_zero(freq_zero),
    .sin_term(sin_term),
    .cos_term(cos_term)
  );

  always_comb begin
    re_full = 48'(ip_y[0]) * 48'(cos_term) - 48'(ip_y[1]) * 48'(sin_term); // R12 R8
    im_full = 48'(ip_y[1]) * 48'(cos_term) + 48'(ip_y[0]) * 48'(sin_term); // R12 R8
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mix_re <= '0;
      mix_im <= '0;
    end else if (freq_zero) begin
      mix_re <= ip_y[0]; // R11
      mix_im <= ip_y[1]; // R11
    end else begin
      mix_re <= sat21(re_full >>> TRIG_SHIFT); // R12
      mix_im <= sat21(im_full >>> TRIG_SHIFT); // R12
    end
  end

  // ---------------- summers, cascade, output routing ----------------
  out_mode_e mode;
  logic cplx;
  logic x2;
  logic strobe_en;
  logic casc_en;
  logic [1:0] casc_delay;
  logic [1:0] cplx_kind;
  logic signed [SAMPLE_W-1:0] sum_re [4];
  logic signed [SAMPLE_W-1:0] sum_im [4];
  logic signed [SAMPLE_W-1:0] dly_re [CASC_DEPTH];
  logic signed [SAMPLE_W-1:0] dly_im [CASC_DEPTH];
  logic signed [SAMPLE_W-1:0] sel_re;
  logic signed [SAMPLE_W-1:0] sel_im;
  logic signed [SAMPLE_W-1:0] casc_re;
  logic signed [SAMPLE_W-1:0] casc_im;
  logic signed [SAMPLE_W-1:0] out_r [4];
  logic signed [SAMPLE_W-1:0] mux_hold [4];
  logic mux_imag;

  assign mode = out_mode_e'(dev_ctrl[DEV_MODE_LSB +: 2]); // R13
  assign cplx = main_ctrl[MAIN_CPLX_BIT]; // R13
  assign x2 = dev_ctrl[DEV_X2_BIT] && mode == MODE_REAL && !cplx; // R21
  assign strobe_en = dev_ctrl[DEV_STRB_EN_BIT];
  assign casc_en = dev_ctrl[DEV_CASC_EN_BIT];
  assign casc_delay = dev_ctrl[DEV_DELAY_LSB +: 2];
  assign cplx_kind = route_ctrl[CPLX_KIND_LSB +: 2];
  assign casc_re = casc_en ? cascade_real_bus_in : '0; // R16
  assign casc_im = casc_en ? cascade_imag_bus_in : '0; // R16
  assign sel_re = casc_delay == 2'h0 ? sum_re[0] : dly_re[casc_delay - 2'h1]; // R15
  assign sel_im = casc_delay == 2'h0 ? sum_im[0] : dly_im[casc_delay - 2'h1]; // R15

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 4; k++) begin
        sum_re[k] <= '0;
        sum_im[k] <= '0;
      end
      for (int k = 0; k < CASC_DEPTH; k++) begin
        dly_re[k] <= '0;
        dly_im[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        // an element of a packed array reads unsigned, so its sign is restored before widening
        sum_re[k] <= sat20(48'($signed(peer_re[k])) +
                           (route_ctrl[ROUTE_LSB + k] ? 48'(mix_re) : 48'sh0));
        sum_im[k] <= sat20(48'($signed(peer_im[k])) +
                           (route_ctrl[ROUTE_LSB + k] ? 48'(mix_im) : 48'sh0));
      end
      dly_re[0] <= sum_re[0]; // R15
      dly_im[0] <= sum_im[0];
      for (int k = 1; k < CASC_DEPTH; k++) begin
        dly_re[k] <= dly_re[k-1];
        dly_im[k] <= dly_im[k-1];
      end
    end
  end

  // the 2x mode uses clk as a select: downstream set-up time is half a period
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_imag <= 1'b0;
      real_sample_strobe <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        out_r[k] <= '0;
        mux_hold[k] <= '0;
      end
    end else begin
      mux_imag <= mode == MODE_MUXED ? !mux_imag : 1'b0;
      real_sample_strobe <= 1'b0;
      case (mode)
        MODE_CASCADE: begin
          out_r[0] <= '0;
          out_r[1] <= '0;
          out_r[2] <= sat20(48'(sel_re) + 48'(casc_re)); // R14 R17
          out_r[3] <= sat20(48'(sel_im) + 48'(casc_im)); // R14 R17
        end
        MODE_REAL: begin
          for (int k = 0; k < 4; k++) out_r[k] <= sum_re[k]; // R18
          if (cplx && (cplx_kind == 2'h1 || cplx_kind == 2'h3)) out_r[1] <= sum_im[0]; // R22
          if (cplx && cplx_kind == 2'h2) out_r[3] <= sum_im[2]; // R22
          if (cplx && cplx_kind == 2'h3) out_r[3] <= sum_im[2]; // R22
        end
        MODE_IMAG: begin
          for (int k = 0; k < 4; k++) out_r[k] <= sum_im[k]; // R18
        end
        MODE_MUXED: begin
          if (!mux_imag) begin
            real_sample_strobe <= strobe_en; // R19 R20
            for (int k = 0; k < 4; k++) begin
              out_r[k] <= sum_re[k]; // R19
              mux_hold[k] <= sum_im[k];
            end
          end else begin
            for (int k = 0; k < 4; k++) out_r[k] <= mux_hold[k]; // R19
          end
        end
        default: ;
      endcase
    end
  end

  assign cascade_real_bus_oe = mode != MODE_CASCADE; // R14
  assign cascade_imag_bus_oe = mode != MODE_CASCADE; // R14
  assign cascade_real_bus_out = x2 ? (clk ? sum_re[0] : sum_im[0]) : out_r[0]; // R21
  assign cascade_imag_bus_out = x2 ? (clk ? sum_re[1] : sum_im[1]) : out_r[1]; // R21
  assign first_output_bus = x2 ? (clk ? sum_re[2] : sum_im[2]) : out_r[2]; // R21
  assign second_output_bus = x2 ? (clk ? sum_re[3] : sum_im[3]) : out_r[3]; // R21

  // ---------------- checks ----------------
  hb_zero_fill_a: assert property (@(posedge clk) disable iff (rst)
    shaped_valid && !hb_en |=> dl[0][0] == '0 && dl[1][0] == '0) // R2
    else $error("bypassed halfband delay line not zeroed");
  hb_center_a: assert property (@(posedge clk) disable iff (rst)
    hb_pend && !in_q |=> hb_valid && hb_y[0] == $past(dl[0][2])) // R3
    else $error("halfband odd phase is not the centre sample");
  hb_default_a: assert property (@(posedge clk)
    rst |=> !hb_en) // R1
    else $error("halfband enabled after reset");
  acc_step_a: assert property (@(posedge clk) disable iff (rst)
    !ofs_load |=> phase_acc == $past(phase_acc) + $past(carrier_freq_word)) // R23
    else $error("carrier accumulator did not advance by the increment");
  acc_preset_a: assert property (@(posedge clk) disable iff (rst)
    wr_fire && aw_idx == IDX_PHASE_OFS |=> ##1 phase_acc[15:0] == 16'h0000 &&
    phase_acc[31:16] == carrier_phase_offset_word) // R9
    else $error("phase offset load wrong");
  zero_freq_a: assert property (@(posedge clk) disable iff (rst)
    freq_zero ##1 freq_zero |-> sin_term == '0 && cos_term == COS_ONE ##1
    (!freq_zero || mix_re == $past(ip_y[0]))) // R11
    else $error("zero frequency does not pass samples through");
  strobe_gate_a: assert property (@(posedge clk) disable iff (rst)
    !$past(strobe_en) |-> !real_sample_strobe) // R20
    else $error("strobe driven while disabled");
  mux_alt_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_MUXED && strobe_en [*3] |-> real_sample_strobe != $past(real_sample_strobe)) // R19
    else $error("muxed strobe does not alternate");
  casc_dir_a: assert property (@(posedge clk) disable iff (rst)
    cascade_real_bus_oe == (mode != MODE_CASCADE) && cascade_imag_bus_oe == cascade_real_bus_oe) // R14
    else $error("cascade bus direction wrong");
  real_route_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_REAL && !cplx && !x2 ##1 mode == MODE_REAL && !cplx && !x2
    |-> first_output_bus == $past(sum_re[2])) // R18
    else $error("real mode routing wrong");
  casc_zero_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_CASCADE && !casc_en && casc_delay == 2'h0 ##1 mode == MODE_CASCADE
    |-> first_output_bus == $past(sum_re[0])) // R16
    else $error("disabled cascade input not zeroed");
endmodule

// ---- tb/cascade_source.sv ----
`timescale 1ns/10ps
module cascade_source (
  // clock
  input wire logic clk,
  // device drive enables
  input wire logic oe_re,
  input wire logic oe_im,
  // upstream cascade samples
  input wire logic signed [19:0] re_val,
  input wire logic signed [19:0] im_val,
  // this side's drive onto the cascade wires
  output logic signed [19:0] re_drv,
  output logic signed [19:0] im_drv
);
  logic signed [19:0] re_last = '0;
  logic signed [19:0] im_last = '0;
  // released lines show the inverse, so a stale copy never passes for data
  assign re_drv = oe_re ? ~re_last : re_val;
  assign im_drv = oe_im ? ~im_last : im_val;
  always_ff @(posedge clk) begin
    re_last <= re_drv;
    im_last <= im_drv;
  end
endmodule

// ---- tb/upconverter_channel_back_end_test.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR at %0t: got %h expected %h", $time, a, e); end end
module upconverter_channel_back_end_test;
  import upc_pkg::*;
  logic clk = '0, rst = '1, awv = '0, wv = '0, br = '0, arv = '0, rr = '0, probe = '0;
  logic awr, wr, bv, arr, rv, coer, coei, strb;
  logic [1:0] bresp, rresp;
  logic [8:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdata, seed = 32'h9F6CADD3;
  logic signed [20:0] pr [4] = '{default: '0};
  logic signed [20:0] pi [4] = '{default: '0};
  logic signed [19:0] crv = '0, civ = '0, rdrv, idrv, cro, cio, fo, so;
  logic [33:0] rq [$];
  logic [81:0] oq [$];
  logic [33:0] eb;
  logic [81:0] eo;
  int mismatches = 0, n_checks = 0;
  always #50 clk = ~clk;
  upconverter_channel_back_end u_upconverter_channel_back_end (.clk(clk), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .shaped_i(20'sh0), .shaped_q(20'sh0), .shaped_valid(1'h0),
    .fine_phase(8'h00), .peer_re({pr[3], pr[2], pr[1], pr[0]}),
    .peer_im({pi[3], pi[2], pi[1], pi[0]}), .cascade_real_bus_in(coer ? cro : rdrv),
    .cascade_real_bus_out(cro), .cascade_real_bus_oe(coer),
    .cascade_imag_bus_in(coei ? cio : idrv), .cascade_imag_bus_out(cio),
    .cascade_imag_bus_oe(coei), .first_output_bus(fo), .second_output_bus(so),
    .real_sample_strobe(strb));
  cascade_source u_cascade_source (.clk(clk), .oe_re(coer), .oe_im(coei), .re_val(crv),
    .im_val(civ), .re_drv(rdrv), .im_drv(idrv));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [19:0] sat_e(input logic signed [21:0] v);
    if (v > 22'sh07FFFF) return 20'h7FFFF;
    if (v < -22'sh07FFFF) return 20'h80001;
    return v[19:0];
  endfunction
  function automatic logic signed [20:0] pv(input int m, input int i);
    return (m == 2) ? pi[i] : pr[i];
  endfunction
  task automatic axw(input logic [6:0] idx, input logic [15:0] d);
    logic a, w, b;
    awa <= {idx, 2'h0};
    wd <= {16'h0000, d};
    awv <= '1;
    wv <= '1;
    br <= '1;
    do begin
      @(negedge clk);
      a = awv && awr;
      w = wv && wr;
      b = bv;
      @(posedge clk);
      if (a) awv <= '0;
      if (w) wv <= '0;
    end while (!b);
  endtask
  task automatic axr(input logic [6:0] idx, input logic [33:0] e);
    logic a, r;
    rq.push_back(e);
    ara <= {idx, 2'h0};
    arv <= '1;
    rr <= '1;
    do begin
      @(negedge clk);
      a = arv && arr;
      r = rv;
      @(posedge clk);
      if (a) arv <= '0;
    end while (!r);
  endtask
  task automatic probe_out(input logic [81:0] e);
    oq.push_back(e);
    probe <= '1;
    @(posedge clk);
    probe <= '0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // results are judged one edge after they are announced, from the oldest note
  always @(posedge clk) begin
    if (rv && rr) begin eb = rq.pop_front(); `CHK({rresp, rdata}, eb) end
    if (bv && br) `CHK(bresp, RESP_OKAY)
    if (probe) begin eo = oq.pop_front(); `CHK({coer, coei, cro, cio, fo, so}, eo) end
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    logic en;
    repeat (3) @(posedge clk);
    rst <= '0;
    @(posedge clk);
    axw(IDX_FREQ_HI, 16'h0000);
    axw(IDX_FREQ_LO, 16'h0000);
    axw(IDX_PHASE_OFS, 16'hA5C3);
    axr(IDX_PHASE_OFS, {RESP_OKAY, 32'h0000A5C3});
    axr(IDX_STATUS, {RESP_OKAY, 32'h0000A5C3});
    axr(7'h55, {RESP_SLVERR, 32'h00000000});
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 3; k++) begin
        en = (k != 0);
        axw(IDX_DEV_CTRL, {6'h00, 2'(m), 4'h0, en, 3'h0});
        for (int i = 0; i < 4; i++) begin
          seed = lfsr(seed);
          pr[i] <= 21'(signed'(seed[19:0]));
          pi[i] <= 21'(signed'(seed[31:12]));
        end
        crv <= seed[25:6];
        civ <= seed[29:10];
        // full-scale pair to drive both sums past the clamp in cascade mode
        if (k == 2) begin
          pr[0] <= 21'h07FF00;
          pi[0] <= 21'h180100;
          crv <= 20'h7FF00;
          civ <= 20'h80100;
        end
        repeat (3) @(posedge clk);
        if (m == 0) probe_out({2'h0, 40'h0, sat_e(pr[0] + (en ? crv : 20'sh0)),
          sat_e(pi[0] + (en ? civ : 20'sh0))});
        else probe_out({2'h3, sat_e(pv(m, 0)), sat_e(pv(m, 1)),
          sat_e(pv(m, 2)), sat_e(pv(m, 3))});
      end
      $display("test routing mode %0d done", m);
    end
    axw(IDX_DEV_CTRL, 16'h0320);
    repeat (3) @(posedge clk);
    en = strb;
    `CHK(fo, en ? sat_e(pr[2]) : sat_e(pi[2]))
    @(posedge clk);
    `CHK(strb, !en)
    $display("test muxed mode done");
    @(posedge clk);
    complete_run();
  end
endmodule
